// [verification/dffi_bus_mem.sv]
// dffi_bus_mem: host memory and arbiter on the system bus
`timescale 1ns/100ps
module dffi_bus_mem (
	// clock and pace
	input wire logic clk,
	input wire logic slow,
	// bus
	input wire logic bus_req,
	output logic bus_grant,
	input wire logic bus_rd,
	input wire logic [23:0] bus_addr,
	output logic bus_ack,
	output logic [7:0] bus_rdata
);
	logic [7:0] mem [int];
	int wait_n = 0;
	logic rd_seen = 1'b0;
	initial begin
		bus_grant = 1'b0;
		bus_ack = 1'b0;
		bus_rdata = 8'h5a;
	end
	always @(posedge clk) begin
		#1;
		if (!bus_req)
			wait_n = slow ? 3 : 0;
		else if (wait_n > 0)
			wait_n--;
		bus_grant = bus_req && wait_n == 0;
		// slow reads stretch one cycle so a held read is exercised
		if (bus_ack || !bus_rd || wait_n != 0 || (slow && !rd_seen)) begin
			bus_ack = 1'b0;
			// released data inverts each cycle, so it alternates between the last byte and its inverse
			bus_rdata = ~bus_rdata;
		end else begin
			bus_ack = 1'b1;
			bus_rdata = mem.exists(int'(bus_addr)) ? mem[int'(bus_addr)] : 8'hff;
		end
		rd_seen = bus_rd;
	end
endmodule // dffi_bus_mem

// [verification/dffi_properties.sv]
// dffi_properties: port checks of the fetch front end
`timescale 1ns/100ps
module dffi_properties (
	// clock, reset, strap
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic MASTER_MODE,
	// host port
	input wire logic CMD_WR,
	input wire logic CMD_DATA_SEL,
	input wire logic [7:0] CMD_DATA,
	input wire logic CMD_READY,
	input wire logic IRQ,
	// bus and processor
	input wire logic BUS_REQ,
	input wire logic BUS_GRANT,
	input wire logic BUS_RD,
	input wire logic [dffi_pkg::ADDR_W-1:0] BUS_ADDR,
	input wire logic BUS_ACK,
	input wire logic INSN_VALID,
	input wire logic INSN_READY,
	input wire dffi_pkg::dffi_insn_t INSN,
	input wire logic EXEC_BUSY
);
	import dffi_pkg::*;
	// ack or soft reset may clear held state
	wire clr = CMD_WR && !CMD_DATA_SEL && (CMD_DATA == CMD_IRQ_ACK || CMD_DATA == CMD_RESET);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	a_slave_bus_idle: assert property (!MASTER_MODE |-> !BUS_REQ && !BUS_RD)
		else $error("bus used in slave mode");
	a_read_in_req: assert property (BUS_RD |-> BUS_REQ)
		else $error("read without request");
	a_read_granted: assert property ($rose(BUS_RD) |-> $past(BUS_GRANT) && $past(BUS_REQ))
		else $error("read without grant");
	a_ack_ends_read: assert property (BUS_RD && BUS_ACK |=> !BUS_REQ && !BUS_RD)
		else $error("read kept after ack");
	a_read_addr_held: assert property (BUS_RD && !BUS_ACK && !clr |=> BUS_RD && $stable(BUS_ADDR))
		else $error("read dropped or moved");
	a_busy_no_fetch: assert property ($rose(BUS_REQ) |-> !$past(EXEC_BUSY))
		else $error("fetch while busy");
	a_refuse_full: assert property (!CMD_READY |-> CMD_DATA_SEL && !MASTER_MODE)
		else $error("port refused");
	a_irq_sticky: assert property (IRQ && !clr |=> IRQ)
		else $error("irq dropped");
	a_insn_held: assert property (INSN_VALID && !INSN_READY && !clr |=> INSN_VALID && $stable(INSN))
		else $error("insn lost");
endmodule // dffi_properties

bind dffi_top dffi_properties chk_u (.CLK, .SYS_RST, .MASTER_MODE, .CMD_WR, .CMD_DATA_SEL, .CMD_DATA, .CMD_READY,
	.IRQ, .BUS_REQ, .BUS_GRANT, .BUS_RD, .BUS_ADDR, .BUS_ACK, .INSN_VALID, .INSN_READY, .INSN, .EXEC_BUSY);

// [verification/tb.sv]
// tb: random and corner tests of the fetch front end
`timescale 1ns/100ps
module tb;
	import dffi_pkg::*;
	logic CLK = 1'b0, SYS_RST = 1'b1, MASTER_MODE = 1'b0, CMD_WR = 1'b0, CMD_DATA_SEL = 1'b0;
	logic INSN_READY = 1'b0, EXEC_BUSY = 1'b0, stall = 1'b1, slow = 1'b0, took = 1'b0;
	logic [7:0] CMD_DATA = 8'h00;
	logic CMD_READY, IRQ, BUS_REQ, BUS_GRANT, BUS_RD, BUS_ACK, INSN_VALID, COORD_VALID, RUNNING;
	logic [23:0] BUS_ADDR;
	logic [7:0] BUS_RDATA;
	dffi_insn_t INSN;
	dffi_coord_t COORD;
	dffi_insn_t got[$], want[$];
	dffi_coord_t cvals[$];
	logic [23:0] addrs[$], wadr[$];
	int n_errors = 0, checked = 0;
	always #25 CLK = ~CLK;
	dffi_top dut_u (.CLK, .SYS_RST, .MASTER_MODE, .CMD_WR, .CMD_DATA_SEL, .CMD_DATA, .CMD_READY, .IRQ, .BUS_REQ,
		.BUS_GRANT, .BUS_RD, .BUS_ADDR, .BUS_ACK, .BUS_RDATA, .INSN_VALID, .INSN_READY, .INSN, .EXEC_BUSY, .COORD,
		.COORD_VALID, .RUNNING);
	dffi_bus_mem mem_u (.clk(CLK), .slow, .bus_req(BUS_REQ), .bus_grant(BUS_GRANT), .bus_rd(BUS_RD),
		.bus_addr(BUS_ADDR), .bus_ack(BUS_ACK), .bus_rdata(BUS_RDATA));
	// random stalls and busy spells
	always @(posedge CLK) begin
		#1;
		INSN_READY = !stall && $urandom_range(3) != 0;
		EXEC_BUSY = MASTER_MODE && $urandom_range(3) == 0;
	end
	always @(posedge CLK) begin
		if (!SYS_RST && INSN_VALID && INSN_READY)
			got.push_back(INSN);
		if (!SYS_RST && COORD_VALID)
			cvals.push_back(COORD);
		if (!SYS_RST && BUS_RD && BUS_ACK)
			addrs.push_back(BUS_ADDR);
	end
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d, checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	// lim 0 tries once and notes a refusal
	task automatic wr(logic sel, logic [7:0] d, int lim);
		int k = 0;
		CMD_WR = 1'b1;
		CMD_DATA_SEL = sel;
		CMD_DATA = d;
		while (!CMD_READY && k < lim) begin
			cyc(1);
			k++;
		end
		took = CMD_READY;
		if (!took && lim > 0) begin
			n_errors++;
			end_of_test();
		end
		cyc(1);
	endtask
	task automatic put(logic [23:0] a, logic [7:0] d);
		mem_u.mem[int'(a)] = d;
	endtask
	function automatic dffi_coord_t wrap(logic [7:0] xl, logic [7:0] xh, logic [7:0] yl, logic [7:0] yh);
		return {xh[2:0], xl, yh[2:0], yl};
	endfunction
	task automatic reset(logic m);
		SYS_RST = 1'b1;
		MASTER_MODE = m;
		cyc(3);
		SYS_RST = 1'b0;
		cvals.delete();
		addrs.delete();
		check("running", RUNNING, !m);
	endtask
	task automatic drain();
		int k = 0;
		while (got.size() < want.size() && k < 4000) begin
			cyc(1);
			k++;
		end
		check("byte count", got.size(), want.size());
		if (k == 4000)
			end_of_test();
		foreach (want[i])
			check("insn", got[i], want[i]);
		got.delete();
		want.delete();
	endtask
	initial begin
		logic [7:0] b[$];
		logic [7:0] m;
		logic [23:0] s, t, u;
		int n, k;
		void'($urandom(32'he04bd332));
		reset(1'b0);
		// fill while stalled until the port refuses
		n = 0;
		took = 1'b1;
		while (took && n < 300) begin
			m = 8'($urandom_range(8'he0));
			wr(1'b1, m, 0);
			if (took) begin
				want.push_back({1'b1, m});
				n++;
			end
		end
		CMD_WR = 1'b0;
		check("block fits", n, FIFO_DEPTH + 2);
		stall = 1'b0;
		drain();
		cyc(4);
		check("empty irq", IRQ, 1'b1);
		wr(1'b0, CMD_IRQ_ACK, 10);
		CMD_WR = 1'b0;
		cyc(1);
		check("irq acked", IRQ, 1'b0);
		for (int i = 0; i < 16; i++) begin
			m = 8'($urandom);
			if (i % 5 == 0)
				m = i == 0 ? NOP_ENTER_INTERP : i == 5 ? GOP_MOVE : i == 10 ? GOP_ENTER_NATIVE : 8'h42;
			b.push_back(m);
			want.push_back({i < 5 || i == 15, m});
			wr(1'b1, m, 20);
		end
		CMD_WR = 1'b0;
		drain();
		check("coord", cvals[0], wrap(b[6], b[7], b[8], b[9]));
		// master: gosub, return, goto into a linked file
		reset(1'b1);
		slow = 1'b1;
		s = {8'($urandom), 16'h0100};
		t = s + 24'h000200;
		u = s + 24'h000400;
		for (int i = 0; i < 13; i++)
			put(s + 24'(i), 8'($urandom));
		put(s, NOP_ENTER_INTERP);
		put(s + 24'h5, GOP_GOSUB);
		put(s + 24'h9, GOP_GOTO);
		for (int i = 0; i < 3; i++) begin
			put(s + 24'(6 + i), t[23 - 8 * i -: 8]);
			put(s + 24'(10 + i), u[23 - 8 * i -: 8]);
		end
		for (int i = 0; i < 6; i++)
			put(t + 24'(i), i == 0 ? GOP_MOVE : i == 5 ? GOP_END : 8'($urandom));
		put(u, GOP_END);
		for (int i = 0; i < 20; i++)
			wadr.push_back(i < 9 ? s + 24'(i) : i < 15 ? t + 24'(i - 9) : i < 19 ? s + 24'(i - 6) : u);
		foreach (wadr[i])
			want.push_back({i < 5, mem_u.mem[int'(wadr[i])]});
		wr(1'b0, CMD_LOAD_ADDR, 10);
		for (int i = 2; i >= 0; i--)
			wr(1'b0, s[8 * i +: 8], 10);
		wr(1'b0, CMD_CONTINUE, 10);
		CMD_WR = 1'b0;
		check("run", RUNNING, 1'b1);
		k = 0;
		while (addrs.size() < 3 && k < 500) begin
			cyc(1);
			k++;
		end
		if (k == 500) begin
			n_errors++;
			end_of_test();
		end
		wr(1'b0, CMD_STOP, 10);
		CMD_WR = 1'b0;
		cyc(6);
		n = 0;
		repeat (20) begin
			n += BUS_REQ;
			cyc(1);
		end
		check("stopped bus", n, 0);
		wr(1'b0, CMD_CONTINUE, 10);
		CMD_WR = 1'b0;
		k = 0;
		while (!IRQ && k < 3000) begin
			cyc(1);
			k++;
		end
		check("done irq", IRQ, 1'b1);
		if (k == 3000)
			end_of_test();
		drain();
		check("fetches", addrs.size(), 20);
		foreach (wadr[i])
			check("fetch addr", addrs[i], wadr[i]);
		check("coord", cvals[0], wrap(mem_u.mem[int'(t + 24'h1)], mem_u.mem[int'(t + 24'h2)],
			mem_u.mem[int'(t + 24'h3)], mem_u.mem[int'(t + 24'h4)]));
		check("run ended", RUNNING, 1'b0);
		// soft reset drops the pending done irq but keeps the strap
		wr(1'b0, CMD_RESET, 10);
		CMD_WR = 1'b0;
		check("soft reset irq", IRQ, 1'b0);
		check("strap kept", RUNNING, 1'b0);
		end_of_test();
	end
endmodule // tb

// [verilog/dffi_fifo.sv]
// dffi_fifo: 256-byte display file FIFO
`timescale 1ns/100ps
module dffi_fifo (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data
);
	import dffi_pkg::*;

	logic [7:0] mem [0:FIFO_DEPTH-1];
	logic [FIFO_AW-1:0] wr_ptr;
	logic [FIFO_AW-1:0] rd_ptr;
	logic [FIFO_AW:0] count;
	wire do_wr;
	wire do_rd;

	assign in_ready = (count != FIFO_FULL);
	assign out_valid = (count != 9'h000);
	assign out_data = mem[rd_ptr];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;

	// storage carries no reset; only the pointers matter
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || flush) begin
			wr_ptr <= 8'h00;
			rd_ptr <= 8'h00;
			count <= 9'h000;
		end else begin
			wr_ptr <= wr_ptr + 8'(do_wr);
			rd_ptr <= rd_ptr + 8'(do_rd);
			count <= count + 9'(do_wr) - 9'(do_rd);
		end
	end
endmodule // dffi_fifo

// [verilog/dffi_pkg.sv]
// dffi_pkg: constants and carrier types of the display file fetch interpreter
package dffi_pkg;
	localparam int ADDR_W = 24;
	localparam logic [23:0] PTR_RESET = 24'h000000;
	localparam int FIFO_DEPTH = 256;
	localparam int FIFO_AW = 8;
	localparam logic [8:0] FIFO_FULL = 9'h100;
	localparam int COORD_W = 11;
	localparam int STACK_DEPTH = 4;
	localparam logic [2:0] STACK_FULL = 3'h4;
	// host command codes, first byte of each command
	localparam logic [7:0] CMD_LOAD_ADDR = 8'h01;
	localparam logic [7:0] CMD_RESET = 8'h02;
	localparam logic [7:0] CMD_STOP = 8'h03;
	localparam logic [7:0] CMD_CONTINUE = 8'h04;
	localparam logic [7:0] CMD_IRQ_ACK = 8'h05;
	localparam logic [1:0] LOAD_ADDR_ARGS = 2'h3;
	// native-mode opcode that engages the interpreter
	localparam logic [7:0] NOP_ENTER_INTERP = 8'hf1;
	// graphics-mode flow, switch and move opcodes
	localparam logic [7:0] GOP_END = 8'h00;
	localparam logic [7:0] GOP_GOTO = 8'h01;
	localparam logic [7:0] GOP_GOSUB = 8'h02;
	localparam logic [7:0] GOP_RETURN = 8'h03;
	localparam logic [7:0] GOP_ENTER_NATIVE = 8'h05;
	localparam logic [7:0] GOP_MOVE = 8'h10;
	// operand byte counts after the opcode
	localparam logic [2:0] ADDR_ARGS = 3'h3;
	localparam logic [2:0] COORD_ARGS = 3'h4;
	localparam logic [2:0] SWITCH_ARGS = 3'h4;

	typedef struct packed {
		logic native;
		logic [7:0] data;
	} dffi_insn_t;

	typedef struct packed {
		logic [COORD_W-1:0] x;
		logic [COORD_W-1:0] y;
	} dffi_coord_t;
endpackage

// [verilog/dffi_skid.sv]
// dffi_skid: two-entry buffer toward the local processor
`timescale 1ns/100ps
module dffi_skid (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire dffi_pkg::dffi_insn_t in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output dffi_pkg::dffi_insn_t out_data
);
	import dffi_pkg::*;

	dffi_insn_t slot1;
	logic [1:0] cnt;
	wire push;
	wire pop;

	assign in_ready = (cnt != 2'h2);
	assign out_valid = (cnt != 2'h0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (rst || flush) begin
			cnt <= 2'h0;
			out_data <= '0;
			slot1 <= '0;
		end else begin
			cnt <= cnt + 2'(push) - 2'(pop);
			if (pop) begin
				out_data <= (cnt == 2'h2) ? slot1 : in_data;
			end else if (push && cnt == 2'h0) begin
				out_data <= in_data;
			end
			if (push && (cnt == 2'h2 || (cnt == 2'h1 && !pop))) begin
				slot1 <= in_data;
			end
		end
	end
endmodule // dffi_skid

// [verilog/dffi_top.sv]
// dffi_top: display file fetch, decode and host command front end
`timescale 1ns/100ps
module dffi_top (
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// mode strap, high for bus master
	input wire logic MASTER_MODE,
	// host command port
	input wire logic CMD_WR,
	input wire logic CMD_DATA_SEL,
	input wire logic [7:0] CMD_DATA,
	output logic CMD_READY,
	output logic IRQ,
	// system bus master side
	output logic BUS_REQ,
	input wire logic BUS_GRANT,
	output logic BUS_RD,
	output logic [dffi_pkg::ADDR_W-1:0] BUS_ADDR,
	input wire logic BUS_ACK,
	input wire logic [7:0] BUS_RDATA,
	// local processor side
	output logic INSN_VALID,
	input wire logic INSN_READY,
	output dffi_pkg::dffi_insn_t INSN,
	input wire logic EXEC_BUSY,
	output dffi_pkg::dffi_coord_t COORD,
	output logic COORD_VALID,
	output logic RUNNING
);
	import dffi_pkg::*;

	typedef enum logic [1:0] {F_IDLE, F_REQ, F_RD} dffi_fetch_t;
	typedef enum logic [2:0] {P_NONE, P_GOTO, P_GOSUB, P_MOVE, P_GFX, P_NAT} dffi_pend_t;

	// mode and run state
	logic master;
	logic halted;
	logic file_run;
	logic native;
	logic [ADDR_W-1:0] ptr;
	dffi_fetch_t fstate;
	dffi_fetch_t next_fstate;

	// host command parsing
	logic [1:0] ld_args;
	logic [15:0] ld_sh;

	// instruction decode
	logic [2:0] args;
	dffi_pend_t pend;
	logic [23:0] arg_sh;
	logic [ADDR_W-1:0] stack [0:STACK_DEPTH-1];
	logic [2:0] sp;

	// interrupt sources
	logic irq_done;
	logic irq_empty;
	logic empty_q;

	// host command decode
	wire cmd_ctl;
	wire cmd_dat;
	wire ctl_op;
	wire ctl_arg;
	wire soft_rst;
	wire c_load;
	wire c_stop;
	wire c_cont;
	wire c_ack;
	wire ld_done;
	wire [ADDR_W-1:0] ld_addr;

	assign cmd_ctl = CMD_WR && !CMD_DATA_SEL;
	assign cmd_dat = CMD_WR && CMD_DATA_SEL && !master;
	assign ctl_arg = cmd_ctl && (ld_args != 2'h0);
	assign ctl_op = cmd_ctl && (ld_args == 2'h0);
	assign soft_rst = ctl_op && (CMD_DATA == CMD_RESET);
	assign c_load = ctl_op && (CMD_DATA == CMD_LOAD_ADDR);
	assign c_stop = ctl_op && (CMD_DATA == CMD_STOP);
	assign c_cont = ctl_op && (CMD_DATA == CMD_CONTINUE);
	assign c_ack = ctl_op && (CMD_DATA == CMD_IRQ_ACK);
	assign ld_done = ctl_arg && (ld_args == 2'h1);
	assign ld_addr = {ld_sh, CMD_DATA};

	// run gate
	wire go;

	assign go = !halted && (!master || file_run);
	assign RUNNING = go;

	// fifo and fetch wiring
	wire fifo_in_valid;
	wire fifo_in_ready;
	wire [7:0] fifo_in_data;
	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire fetch_wr;
	wire fetch_start;
	wire skid_ready;
	wire pop;

	assign fetch_wr = (fstate == F_RD) && BUS_ACK;
	assign fifo_in_valid = master ? fetch_wr : cmd_dat;
	assign fifo_in_data = master ? BUS_RDATA : CMD_DATA;
	// host data bytes in master mode are swallowed, never stalled
	assign CMD_READY = !CMD_DATA_SEL || master || fifo_in_ready;
	// one byte in flight keeps jumps coherent with the fetch pointer
	assign fetch_start = master && go && !fifo_out_valid && !EXEC_BUSY;
	assign pop = fifo_out_valid && go && skid_ready;

	dffi_fifo u_fifo (
		.clk(CLK),
		.rst(SYS_RST),
		.flush(soft_rst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out_data)
	);

	dffi_skid u_skid (
		.clk(CLK),
		.rst(SYS_RST),
		.flush(soft_rst),
		.in_valid(pop),
		.in_ready(skid_ready),
		.in_data(dffi_insn_t'{native: native, data: fifo_out_data}),
		.out_valid(INSN_VALID),
		.out_ready(INSN_READY),
		.out_data(INSN)
	);

	// instruction decode
	wire dec_op;
	wire dec_arg;
	wire arg_last;
	wire [31:0] full_arg;
	wire op_interp;
	wire op_native;
	wire op_end;
	wire op_ret;
	wire op_goto;
	wire op_gosub;
	wire op_move;
	wire do_pop;
	wire file_done;
	wire do_jump;
	wire do_push;
	wire [1:0] sp_top;

	assign dec_op = pop && (args == 3'h0);
	assign dec_arg = pop && (args != 3'h0);
	assign arg_last = dec_arg && (args == 3'h1);
	assign full_arg = {arg_sh, fifo_out_data};
	assign op_interp = dec_op && native && (fifo_out_data == NOP_ENTER_INTERP);
	assign op_native = dec_op && !native && (fifo_out_data == GOP_ENTER_NATIVE);
	assign op_end = dec_op && !native && (fifo_out_data == GOP_END);
	assign op_ret = dec_op && !native && (fifo_out_data == GOP_RETURN);
	assign op_goto = dec_op && !native && (fifo_out_data == GOP_GOTO);
	assign op_gosub = dec_op && !native && (fifo_out_data == GOP_GOSUB);
	assign op_move = dec_op && !native && (fifo_out_data == GOP_MOVE);
	assign sp_top = 2'(sp - 3'h1);
	assign do_pop = (op_end || op_ret) && (sp != 3'h0);
	assign file_done = op_end && (sp == 3'h0);
	assign do_jump = arg_last && (pend == P_GOTO || pend == P_GOSUB);
	// a call beyond the stack depth still jumps but cannot return
	assign do_push = arg_last && (pend == P_GOSUB) && (sp != STACK_FULL);

	// pointer priority: reset, host load, jump, return, fetch step
	wire [ADDR_W-1:0] next_ptr;

	assign next_ptr = soft_rst ? PTR_RESET :
		ld_done ? ld_addr :
		do_jump ? full_arg[ADDR_W-1:0] :
		do_pop ? stack[sp_top] :
		fetch_wr ? ptr + 24'h000001 :
		ptr;

	// fetch sequencer: request, win, read, release for each byte
	always_comb begin
		next_fstate = fstate;
		case (fstate)
			F_IDLE: begin
				if (fetch_start) begin
					next_fstate = F_REQ;
				end
			end
			F_REQ: begin
				if (!go) begin
					next_fstate = F_IDLE;
				end else if (BUS_GRANT) begin
					next_fstate = F_RD;
				end
			end
			F_RD: begin
				if (BUS_ACK) begin
					next_fstate = F_IDLE;
				end
			end
			default: begin
				next_fstate = F_IDLE;
			end
		endcase
	end

	assign BUS_REQ = (fstate != F_IDLE);
	assign BUS_RD = (fstate == F_RD);
	assign BUS_ADDR = ptr;

	always_ff @(posedge CLK) begin
		if (SYS_RST || soft_rst) begin
			fstate <= F_IDLE;
			ptr <= PTR_RESET;
		end else begin
			fstate <= next_fstate;
			ptr <= next_ptr;
		end
	end

	// strap is sampled while reset is held, then frozen
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			master <= MASTER_MODE;
		end
	end

	// host command state
	always_ff @(posedge CLK) begin
		if (SYS_RST || soft_rst) begin
			ld_args <= 2'h0;
			ld_sh <= 16'h0000;
			halted <= 1'b0;
			file_run <= 1'b0;
		end else begin
			if (c_load) begin
				ld_args <= LOAD_ADDR_ARGS;
			end else if (ctl_arg) begin
				ld_args <= ld_args - 2'h1;
				ld_sh <= {ld_sh[7:0], CMD_DATA};
			end
			if (c_stop) begin
				halted <= 1'b1;
			end else if (c_cont) begin
				halted <= 1'b0;
			end
			if (c_cont) begin
				file_run <= 1'b1;
			end else if (file_done) begin
				file_run <= 1'b0;
			end
		end
	end

	// decode state and interpretation mode
	always_ff @(posedge CLK) begin
		if (SYS_RST || soft_rst) begin
			args <= 3'h0;
			pend <= P_NONE;
			arg_sh <= 24'h000000;
			native <= 1'b1;
			sp <= 3'h0;
		end else begin
			if (dec_arg) begin
				args <= args - 3'h1;
				arg_sh <= full_arg[23:0];
			end else if (op_interp) begin
				args <= SWITCH_ARGS;
				pend <= P_GFX;
			end else if (op_native) begin
				args <= SWITCH_ARGS;
				pend <= P_NAT;
			end else if (op_goto || op_gosub) begin
				args <= ADDR_ARGS;
				pend <= op_goto ? P_GOTO : P_GOSUB;
			end else if (op_move) begin
				args <= COORD_ARGS;
				pend <= P_MOVE;
			end
			if (arg_last && pend == P_GFX) begin
				native <= 1'b0;
			end else if (arg_last && pend == P_NAT) begin
				native <= 1'b1;
			end
			if (do_push) begin
				sp <= sp + 3'h1;
			end else if (do_pop) begin
				sp <= sp - 3'h1;
			end
		end
	end

	// return addresses; ptr already points past the operands
	always_ff @(posedge CLK) begin
		if (do_push) begin
			stack[sp[1:0]] <= ptr;
		end
	end

	// coordinates: low byte first, upper five bits dropped
	always_ff @(posedge CLK) begin
		if (SYS_RST || soft_rst) begin
			COORD <= '0;
			COORD_VALID <= 1'b0;
		end else begin
			COORD_VALID <= arg_last && (pend == P_MOVE);
			if (arg_last && pend == P_MOVE) begin
				COORD.x <= {full_arg[18:16], full_arg[31:24]};
				COORD.y <= {full_arg[2:0], full_arg[15:8]};
			end
		end
	end

	// sticky interrupt causes; a new event beats the acknowledge
	always_ff @(posedge CLK) begin
		if (SYS_RST || soft_rst) begin
			irq_done <= 1'b0;
			irq_empty <= 1'b0;
			empty_q <= 1'b1;
		end else begin
			empty_q <= !fifo_out_valid;
			if (file_done) begin
				irq_done <= 1'b1;
			end else if (c_ack) begin
				irq_done <= 1'b0;
			end
			if (!master && !fifo_out_valid && !empty_q) begin
				irq_empty <= 1'b1;
			end else if (c_ack) begin
				irq_empty <= 1'b0;
			end
		end
	end

	assign IRQ = irq_done || irq_empty;
endmodule // dffi_top
